// ### ducc_regs.svh
`ifndef DUCC_REGS_SVH
`define DUCC_REGS_SVH
// Register offsets on the serial port (7-bit address).
`define DUCC_ADDR_CONFIG 7'h10
`define DUCC_ADDR_SYNC 7'h15
`define DUCC_ADDR_RANGE 7'h16
`define DUCC_ADDR_CLAMP 7'h17
`define DUCC_ADDR_MASK1 7'h18
`define DUCC_ADDR_MASK2 7'h19
`define DUCC_ADDR_ALARM 7'h1A
`define DUCC_ADDR_TRIG 7'h1C
`define DUCC_ADDR_CODE0 7'h30
`define DUCC_ADDR_CODE7 7'h37
`define DUCC_ADDR_LIMA 7'h4E
`define DUCC_ADDR_LIMB 7'h4F
// Field positions.
`define DUCC_LOOP_EN_BIT 0
`define DUCC_WREL_BIT 6
`define DUCC_TRIG_BIT 0
// Reset values.
`define DUCC_CFG_RST 8'h00
`define DUCC_SYNC_RST 8'h00
`define DUCC_RANGE_RST 8'h00
`define DUCC_CLAMP_RST 6'h3F
`define DUCC_MASK_RST 7'h00
`define DUCC_ALARM_RST 6'h00
`define DUCC_CODE_RST 12'h000
`define DUCC_LIMIT_RST 12'hFFF
`define DUCC_PIN_RST 7'h02
`define DUCC_CONV_CLAMP_RST 8'hFF
// Serial frame bit counts (last bit index of command and of frame).
`define DUCC_CMD_LAST 5'h07
`define DUCC_FRAME_LAST 5'h17
`endif

// ### ducc_pkg.sv
package ducc_pkg;
  // Serial frame states, Gray coded along the frame.
  typedef enum logic [1:0] {
    DUCC_IDLE = 2'b00,
    DUCC_CMD = 2'b01,
    DUCC_DATA = 2'b11,
    DUCC_DONE = 2'b10
  } ducc_spi_t;
  typedef logic [11:0] ducc_code_t;
endpackage

// ### ducc_ctrl.sv
`timescale 1ns/10ps
`include "ducc_regs.svh"
module ducc_ctrl
  import ducc_pkg::*;
#(
  parameter int CW = 12
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  input wire logic update_trigger_pin,
  input wire logic clamp_request_pin_1,
  input wire logic clamp_request_pin_2,
  input wire logic supply_out_of_range,
  input wire logic alarm_active,
  input wire logic [3:0][CW-1:0] loop_code,
  input wire logic [3:0] loop_valid,
  output logic [7:0][CW-1:0] conv_code,
  output logic [7:0] conv_clamp,
  output logic [3:0] rail_clamp,
  output logic [7:0] range_sel,
  output logic amplifier_enable_pin
);

  logic [6:0] pin_raw;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] sync3_reg;
  logic [6:0] stable_reg;
  logic [6:0] prev_reg;
  logic sclk_rise;
  logic cs_act;
  logic sdi_bit;
  logic trig_pin_rise;
  logic req1;
  logic req2;
  logic supply_bad;
  ducc_spi_t state_reg;
  logic [4:0] bitcnt_reg;
  logic [23:0] rx_reg;
  logic [15:0] tx_reg;
  logic rd_reg;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;
  logic [7:0] cfg_reg;
  logic [7:0] sync_reg;
  logic [7:0] range_reg;
  logic [5:0] clamp_reg;
  logic [5:0] clamp_next;
  logic [6:0] mask1_reg;
  logic [6:0] mask2_reg;
  logic [5:0] alarm_mask_reg;
  logic alarm_prev_reg;
  logic alarm_rise;
  logic [5:0] pin_force;
  logic [5:0] pin_latch;
  logic [5:0] alarm_set;
  logic [5:0] group_clamp;
  logic trig_evt;
  logic [7:0] code_wr;
  logic loop_en;
  ducc_code_t buf_reg [8];
  ducc_code_t act_reg [8];
  ducc_code_t lim_reg [2];

  // Maps a converter index to its clamp group: two pairs, then four auxiliaries.
  function automatic int unsigned group_of(input int unsigned idx);
    group_of = (idx < 4) ? idx / 2 : idx - 2;
  endfunction

  // Tells whether an address selects converter code register idx.
  function automatic logic code_hit(input logic [6:0] addr, input int unsigned idx);
    code_hit = (addr == (`DUCC_ADDR_CODE0 + 7'(idx)));
  endfunction

  // Read data for an address; unmapped addresses read as zero.
  function automatic logic [15:0] read_data(input logic [6:0] addr);
    read_data = 16'h0000;
    unique case (addr)
      `DUCC_ADDR_CONFIG: read_data = {8'h00, cfg_reg};
      `DUCC_ADDR_SYNC: read_data = {8'h00, sync_reg};
      `DUCC_ADDR_RANGE: read_data = {8'h00, range_reg};
      `DUCC_ADDR_CLAMP: read_data = {10'h000, clamp_reg};
      `DUCC_ADDR_MASK1: read_data = {9'h000, mask1_reg};
      `DUCC_ADDR_MASK2: read_data = {9'h000, mask2_reg};
      `DUCC_ADDR_ALARM: read_data = {10'h000, alarm_mask_reg};
      `DUCC_ADDR_LIMA: read_data = {4'h0, lim_reg[0]};
      `DUCC_ADDR_LIMB: read_data = {4'h0, lim_reg[1]};
      default: read_data = 16'h0000;
    endcase
    for (int i = 0; i < 8; i++) begin
      if (code_hit(addr, i)) begin
        read_data = {4'h0, act_reg[i]};
      end
    end
  endfunction

  // Outside pins pass three flops; a level counts once stages two and three agree.
  assign pin_raw = {supply_out_of_range, clamp_request_pin_2, clamp_request_pin_1,
                    update_trigger_pin, spi_sdi, spi_cs_n, spi_sclk};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg <= `DUCC_PIN_RST;
      sync2_reg <= `DUCC_PIN_RST;
      sync3_reg <= `DUCC_PIN_RST;
      stable_reg <= `DUCC_PIN_RST;
      prev_reg <= `DUCC_PIN_RST;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg ^ sync3_reg));
      prev_reg <= stable_reg;
    end
  end

  assign sclk_rise = stable_reg[0] & ~prev_reg[0];
  assign cs_act = ~stable_reg[1];
  assign sdi_bit = stable_reg[2];
  assign trig_pin_rise = stable_reg[3] & ~prev_reg[3];
  assign req1 = stable_reg[4];
  assign req2 = stable_reg[5];
  assign supply_bad = stable_reg[6];

  // Serial frame: read flag, 7-bit address, 16 data bits, MSB first on rising clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= DUCC_IDLE;
      bitcnt_reg <= 5'h00;
      rx_reg <= 24'h000000;
      tx_reg <= 16'h0000;
      rd_reg <= 1'b0;
    end else if (!cs_act) begin
      state_reg <= DUCC_IDLE;
      bitcnt_reg <= 5'h00;
      rd_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        DUCC_IDLE: begin
          state_reg <= DUCC_CMD;
          bitcnt_reg <= 5'h00;
        end
        DUCC_CMD: begin
          if (sclk_rise) begin
            rx_reg <= {rx_reg[22:0], sdi_bit};
            bitcnt_reg <= bitcnt_reg + 5'h01;
            if (bitcnt_reg == `DUCC_CMD_LAST) begin
              state_reg <= DUCC_DATA;
              tx_reg <= read_data({rx_reg[5:0], sdi_bit});
              rd_reg <= rx_reg[6];
            end
          end
        end
        DUCC_DATA: begin
          if (sclk_rise) begin
            rx_reg <= {rx_reg[22:0], sdi_bit};
            tx_reg <= {tx_reg[14:0], 1'b0};
            bitcnt_reg <= bitcnt_reg + 5'h01;
            if (bitcnt_reg == `DUCC_FRAME_LAST) begin
              state_reg <= DUCC_DONE;
            end
          end
        end
        DUCC_DONE: begin
          rd_reg <= 1'b0;
        end
      endcase
    end
  end

  assign spi_sdo_o = tx_reg[15];
  assign spi_sdo_oe = rd_reg;

  // Write strobe on the last data bit of a write frame.
  assign wr_en = cs_act & sclk_rise & (state_reg == DUCC_DATA) &
                 (bitcnt_reg == `DUCC_FRAME_LAST) & ~rx_reg[22];
  assign wr_addr = rx_reg[21:15];
  assign wr_data = {rx_reg[14:0], sdi_bit};

  // Plain configuration registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg <= `DUCC_CFG_RST;
      sync_reg <= `DUCC_SYNC_RST;
      range_reg <= `DUCC_RANGE_RST;
      mask1_reg <= `DUCC_MASK_RST;
      mask2_reg <= `DUCC_MASK_RST;
      alarm_mask_reg <= `DUCC_ALARM_RST;
      lim_reg[0] <= `DUCC_LIMIT_RST;
      lim_reg[1] <= `DUCC_LIMIT_RST;
    end else if (wr_en) begin
      unique case (wr_addr)
        `DUCC_ADDR_CONFIG: cfg_reg <= wr_data[7:0];
        `DUCC_ADDR_SYNC: sync_reg <= wr_data[7:0];
        `DUCC_ADDR_RANGE: range_reg <= wr_data[7:0];
        `DUCC_ADDR_MASK1: mask1_reg <= wr_data[6:0];
        `DUCC_ADDR_MASK2: mask2_reg <= wr_data[6:0];
        `DUCC_ADDR_ALARM: alarm_mask_reg <= wr_data[5:0];
        `DUCC_ADDR_LIMA: lim_reg[0] <= wr_data[CW-1:0];
        `DUCC_ADDR_LIMB: lim_reg[1] <= wr_data[CW-1:0];
        default: ;
      endcase
    end
  end

  assign range_sel = range_reg;
  assign loop_en = cfg_reg[`DUCC_LOOP_EN_BIT];

  // Clamp sources per group: pins through masks, latched pins, alarm onset.
  assign pin_force = ({6{req1}} & mask1_reg[5:0]) | ({6{req2}} & mask2_reg[5:0]);
  assign pin_latch = ({6{req1 & mask1_reg[`DUCC_WREL_BIT]}} & mask1_reg[5:0]) |
                     ({6{req2 & mask2_reg[`DUCC_WREL_BIT]}} & mask2_reg[5:0]);
  assign alarm_rise = alarm_active & ~alarm_prev_reg;
  assign alarm_set = {6{alarm_rise}} & alarm_mask_reg;

  // Host writes touch only bits no pin is holding; hardware sets win over clears.
  always_comb begin
    clamp_next = clamp_reg;
    if (wr_en && (wr_addr == `DUCC_ADDR_CLAMP)) begin
      clamp_next = (wr_data[5:0] & ~pin_force) | (clamp_reg & pin_force);
    end
    clamp_next = clamp_next | pin_latch | alarm_set;
  end

  // Software clamp register and alarm edge memory.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clamp_reg <= `DUCC_CLAMP_RST;
      alarm_prev_reg <= 1'b0;
    end else begin
      clamp_reg <= clamp_next;
      alarm_prev_reg <= alarm_active;
    end
  end

  // Effective clamp: the rail clamp reaches only the bipolar pairs.
  assign group_clamp = clamp_reg | pin_force | {4'h0, {2{supply_bad}}};

  // Trigger from the register bit or the pin's rising edge.
  assign trig_evt = trig_pin_rise |
                    (wr_en & (wr_addr == `DUCC_ADDR_TRIG) & wr_data[`DUCC_TRIG_BIT]);

  // Clamp state, rail clamp and amplifier enable outputs.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_clamp <= `DUCC_CONV_CLAMP_RST;
      rail_clamp <= 4'h0;
      amplifier_enable_pin <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        conv_clamp[i] <= group_clamp[group_of(i)];
      end
      rail_clamp <= {4{supply_bad}};
      amplifier_enable_pin <= ~|pin_force;
    end
  end

  // Per converter: buffer, active register and update path.
  for (genvar g = 0; g < 8; g++) begin : g_conv
    assign code_wr[g] = wr_en & code_hit(wr_addr, g);

    // Buffer takes every host write, clamped or not.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        buf_reg[g] <= `DUCC_CODE_RST;
      end else if (code_wr[g]) begin
        buf_reg[g] <= wr_data[CW-1:0];
      end
    end

    // Active register: loop, immediate write or triggered transfer.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        act_reg[g] <= `DUCC_CODE_RST;
      end else if ((g < 4) && loop_en && loop_valid[g % 4]) begin
        // Converters 0 and 1 share the first limit, converters 2 and 3 the second.
        act_reg[g] <= (loop_code[g % 4] > lim_reg[(g % 4) / 2]) ? lim_reg[(g % 4) / 2] : loop_code[g % 4];
      end else if (code_wr[g] && !sync_reg[g]) begin
        act_reg[g] <= wr_data[CW-1:0];
      end else if (trig_evt && sync_reg[g]) begin
        act_reg[g] <= buf_reg[g];
      end
    end

    assign conv_code[g] = act_reg[g];
  end

  // Checks.
  reset_clamp_a: assert property (@(posedge mclk) $fell(rst) |-> (conv_clamp == `DUCC_CONV_CLAMP_RST))
    else $error("outputs not clamped after reset");
  sw_clamp_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && wr_addr == `DUCC_ADDR_CLAMP && wr_data[0]) |=> ##1 (conv_clamp[1:0] == 2'b11))
    else $error("software clamp did not clamp pair");
  pin_clamp_a: assert property (@(posedge mclk) disable iff (rst)
    (req1 && mask1_reg[0]) |=> conv_clamp[0])
    else $error("request pin did not clamp");
  pin_ignore_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && wr_addr == `DUCC_ADDR_CLAMP && pin_force[0] && clamp_reg[0]) |=> clamp_reg[0])
    else $error("clamp bit write not ignored under pin");
  supply_clamp_a: assert property (@(posedge mclk) disable iff (rst)
    supply_bad |=> (rail_clamp == 4'hF) && (conv_clamp[3:0] == 4'hF))
    else $error("supply fault did not rail clamp");
  loop_limit_a: assert property (@(posedge mclk) disable iff (rst)
    (loop_en && loop_valid[0]) |=> (act_reg[0] <= lim_reg[0]))
    else $error("loop code above limit");
  async_upd_a: assert property (@(posedge mclk) disable iff (rst)
    (code_wr[0] && !sync_reg[0] && !(loop_en && loop_valid[0])) |=> (act_reg[0] == $past(wr_data[CW-1:0])))
    else $error("asynchronous write did not update");
  sync_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (code_wr[4] && sync_reg[4] && !trig_evt) |=> (act_reg[4] == $past(act_reg[4])))
    else $error("synchronous write updated early");
  trig_xfer_a: assert property (@(posedge mclk) disable iff (rst)
    (trig_evt && sync_reg[5] && !code_wr[5]) |=> (act_reg[5] == $past(buf_reg[5])))
    else $error("trigger did not transfer buffer");
  alarm_latch_a: assert property (@(posedge mclk) disable iff (rst)
    (alarm_rise && alarm_mask_reg[2]) |=> clamp_reg[2] ##1 conv_clamp[4])
    else $error("alarm did not clamp");
  amp_off_a: assert property (@(posedge mclk) disable iff (rst)
    (pin_force != 6'h00) |=> !amplifier_enable_pin)
    else $error("amplifier enabled under pin clamp");

  // Second limit, auxiliary rail isolation, amplifier enable and readback.
  limit_b_a: assert property (@(posedge mclk) disable iff (rst)
    (loop_en && loop_valid[2]) |=> (act_reg[2] <= $past(lim_reg[1])))
    else $error("second loop limit not applied");
  aux_rail_a: assert property (@(posedge mclk) disable iff (rst)
    (supply_bad && ((clamp_reg[5:2] | pin_force[5:2]) == 4'h0)) |=> (conv_clamp[7:4] == 4'h0))
    else $error("auxiliary output rail clamped");
  amp_on_a: assert property (@(posedge mclk) disable iff (rst)
    (pin_force == 6'h00) |=> amplifier_enable_pin)
    else $error("amplifier not enabled without pin clamp");
  read_active_a: assert property (@(posedge mclk) disable iff (rst)
    (cs_act && sclk_rise && (state_reg == DUCC_CMD) && (bitcnt_reg == `DUCC_CMD_LAST) &&
     code_hit({rx_reg[5:0], sdi_bit}, 3)) |=> (tx_reg == {4'h0, $past(act_reg[3])}))
    else $error("code read not taken from active register");

  // Writes under clamp, latched clamp sources and range register writes.
  clamp_write_a: assert property (@(posedge mclk) disable iff (rst)
    (code_wr[1] && conv_clamp[1]) |=> (buf_reg[1] == $past(wr_data[CW-1:0])))
    else $error("code write lost while clamped");
  wrel_hold_a: assert property (@(posedge mclk) disable iff (rst)
    pin_latch[0] |=> clamp_reg[0])
    else $error("write-release clamp not latched");
  alarm_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (clamp_reg[2] && !alarm_active && !(wr_en && (wr_addr == `DUCC_ADDR_CLAMP))) |=> clamp_reg[2])
    else $error("alarm clamp released without host write");
  range_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && (wr_addr == `DUCC_ADDR_RANGE)) |=> (range_sel == $past(wr_data[7:0])))
    else $error("range write not applied");

endmodule

// ### ducc_host.sv
`timescale 1ns/10ps
// Host side of the four-wire serial port: mode 0, one 24-bit frame per call, MSB first.
module ducc_host (
  input wire logic mclk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe
);
  // Idle lines before the first frame.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // Each clock phase lasts six system cycles so the port's synchroniser always sees it.
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 16'h0000;
    @(posedge mclk);
    #1 spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (6) @(posedge mclk);
      #1 spi_sclk = 1'b0;
      spi_sdi = f[i];
      repeat (6) @(posedge mclk);
      #1 if (i < 16) q = {q[14:0], spi_sdo_oe ? spi_sdo_o : 1'bx}; // An undriven data line reads as unknown.
      spi_sclk = 1'b1;
    end
    repeat (6) @(posedge mclk);
    #1 spi_sclk = 1'b0;
    repeat (6) @(posedge mclk);
    #1 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // The data line is not held at its last value between frames.
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ### ducc_ctrl_tb_top.sv
`timescale 1ns/10ps
module ducc_ctrl_tb_top;
  logic mclk = 1'b0, rst = 1'b1, trig = 1'b0, req1 = 1'b0, req2 = 1'b0, bad = 1'b0, alarm = 1'b0;
  logic sclk, cs_n, sdi, sdo_o, sdo_oe, amp_en;
  logic [3:0][11:0] loop_code = '0;
  logic [3:0] loop_valid = '0;
  logic [7:0][11:0] conv_code;
  logic [7:0] conv_clamp, range_sel;
  logic [3:0] rail_clamp;
  int failures = 0, n_checks = 0, v;
  int act_m[8], buf_m[8], lim_m[2], mask_m[2];
  int sync_m = 0, clamp_m = 'h3F, alarm_m = 0, loop_m = 0;
  // System clock at 100 MHz.
  always #5 mclk = ~mclk;
  ducc_host host_u (.mclk(mclk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo_o(sdo_o),
    .spi_sdo_oe(sdo_oe));
  ducc_ctrl dut_u (.mclk(mclk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo_o(sdo_o),
    .spi_sdo_oe(sdo_oe), .update_trigger_pin(trig), .clamp_request_pin_1(req1), .clamp_request_pin_2(req2),
    .supply_out_of_range(bad), .alarm_active(alarm), .loop_code(loop_code), .loop_valid(loop_valid),
    .conv_code(conv_code), .conv_clamp(conv_clamp), .rail_clamp(rail_clamp), .range_sel(range_sel),
    .amplifier_enable_pin(amp_en));
  // Clamp groups to converters: pair bits cover two converters, auxiliary bits one each.
  function automatic logic [7:0] g2c(input int g);
    return {g[5:2], {2{g[1]}}, {2{g[0]}}};
  endfunction
  // Groups currently held by a request pin through its mask.
  function automatic int forced();
    return ((req1 ? mask_m[0] : 0) | (req2 ? mask_m[1] : 0)) & 'h3F;
  endfunction
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Register write on the serial port, mirrored in the reference model.
  task automatic wr(input logic [6:0] a, input int d);
    logic [15:0] q;
    host_u.xfer(1'b0, a, d[15:0], q);
    case (a)
      7'h10: loop_m = d[0];
      7'h15: sync_m = d & 'hFF;
      7'h17: clamp_m = (d & 'h3F & ~forced()) | (clamp_m & forced());
      7'h18, 7'h19: mask_m[a[0]] = d & 'h7F;
      7'h1A: alarm_m = d & 'h3F;
      7'h1C: for (int i = 0; i < 8; i++) if (d[0] && sync_m[i]) act_m[i] = buf_m[i];
      7'h4E, 7'h4F: lim_m[a[0]] = d & 'hFFF;
      default: if (a[6:3] == 4'h6) begin
        buf_m[a[2:0]] = d & 'hFFF;
        if (!sync_m[a[2:0]]) act_m[a[2:0]] = d & 'hFFF;
      end
    endcase
  endtask
  task automatic rd(input logic [6:0] a, input int e, input string n);
    logic [15:0] q;
    host_u.xfer(1'b1, a, 16'h0000, q);
    chk(n, q, e[15:0]);
  endtask
  // Compares converter codes, converter clamps and amplifier enable against the model once synchronisers have settled.
  task automatic cmp_all();
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 8; i++) chk("conv_code", {4'h0, conv_code[i]}, act_m[i][15:0]);
    chk("conv_clamp", {8'h00, conv_clamp}, {8'h00, g2c(clamp_m | forced())});
    chk("amp_en", {15'h0000, amp_en}, {15'h0000, forced() == 0});
  endtask
  task automatic pin(input int p, input logic l);
    @(posedge mclk);
    #1 if (p == 1) req2 = l; else req1 = l;
    if (l && mask_m[p][6]) clamp_m |= mask_m[p] & 'h3F;
  endtask
  task automatic loop(input int i, input int c);
    @(posedge mclk);
    #1 loop_code[i] = c[11:0];
    loop_valid[i] = 1'b1;
    @(posedge mclk);
    #1 loop_valid = '0;
    if (loop_m) act_m[i] = (c > lim_m[i/2]) ? lim_m[i/2] : c;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // About 25k cycles are expected; this 80k-cycle limit leaves a threefold margin.
  initial begin
    #800000;
    failures++;
    results();
  end
  // Main sequence.
  initial begin
    void'($urandom(4));
    foreach (act_m[i]) begin
      act_m[i] = 0;
      buf_m[i] = 0;
    end
    lim_m = '{'hFFF, 'hFFF};
    mask_m = '{0, 0};
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (6) @(posedge mclk);
    cmp_all();
    rd(7'h17, 'h3F, "clamp_reg");
    rd(7'h4F, 'hFFF, "limit_b");
    rd(7'h05, 0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      v = ($urandom & 'hF0) | (k << 2) | (2 - k);
      wr(7'h16, v);
      chk("range_sel", {8'h00, range_sel}, v[15:0]);
      rd(7'h16, v, "range_reg");
    end
    wr(7'h17, 0);
    cmp_all();
    $display("test range done");
    for (int i = 0; i < 8; i++) wr(7'h30 + 7'(i), $urandom & 'hFFF);
    cmp_all();
    for (int i = 0; i < 8; i++) rd(7'h30 + 7'(i), act_m[i], "code_reg");
    wr(7'h15, ($urandom & 'hCF) | 'h30); // Converters 4 and 5 are always synchronous here.
    for (int i = 0; i < 8; i++) wr(7'h30 + 7'(i), $urandom & 'hFFF);
    cmp_all();
    rd(7'h33, act_m[3], "code_reg");
    wr(7'h1C, 1);
    cmp_all();
    for (int i = 0; i < 8; i++) wr(7'h30 + 7'(i), $urandom & 'hFFF);
    @(posedge mclk);
    #1 trig = 1'b1;
    for (int i = 0; i < 8; i++) if (sync_m[i]) act_m[i] = buf_m[i];
    repeat (6) @(posedge mclk);
    #1 trig = 1'b0;
    cmp_all();
    $display("test update done");
    wr(7'h17, 'h3F);
    for (int i = 0; i < 8; i++) wr(7'h30 + 7'(i), $urandom & 'hFFF);
    cmp_all();
    wr(7'h15, 0);
    wr(7'h17, 0);
    cmp_all();
    $display("test clamp done");
    for (int p = 0; p < 2; p++) begin
      v = ($urandom & 'h3F) | 1;
      wr(7'h18 + 7'(p), v);
      pin(p, 1'b1);
      cmp_all();
      wr(7'h17, v);
      pin(p, 1'b0);
      cmp_all();
      wr(7'h18 + 7'(p), v | 'h40);
      pin(p, 1'b1);
      cmp_all();
      wr(7'h17, 0);
      cmp_all();
      pin(p, 1'b0);
      cmp_all();
      wr(7'h17, 0);
      cmp_all();
      wr(7'h18 + 7'(p), 0);
    end
    $display("test pins done");
    wr(7'h1A, 'h26);
    @(posedge mclk);
    #1 alarm = 1'b1;
    clamp_m |= alarm_m;
    cmp_all();
    #1 alarm = 1'b0;
    cmp_all();
    wr(7'h17, 0);
    cmp_all();
    #1 bad = 1'b1;
    repeat (8) @(posedge mclk);
    chk("rail_clamp", {12'h000, rail_clamp}, 16'h000F);
    chk("conv_clamp", {8'h00, conv_clamp}, 16'h000F);
    #1 bad = 1'b0;
    repeat (8) @(posedge mclk);
    chk("rail_clamp", {12'h000, rail_clamp}, 16'h0000);
    $display("test alarm done");
    wr(7'h4E, 'h100 + ($urandom & 'h7FF));
    wr(7'h4F, 'h080 + ($urandom & 'h3FF));
    loop(1, 'hABC);
    cmp_all();
    wr(7'h10, 1);
    loop(0, 'hFFF);
    loop(2, $urandom & 'hFFF);
    loop(1, 0);
    loop(3, 'hFFF);
    cmp_all();
    wr(7'h10, 0);
    loop(3, 'h5A5);
    cmp_all();
    $display("test loop done");
    results();
  end
endmodule
